// ===== rtl/serial_ctrl_pkg.sv
// Purpose: Shared constants of the serial control and status block
// Assumes: 8-bit registers, each on its own 32-bit word of the register bus
// Notes: Register offsets are byte addresses
package serial_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_TX_HOLD = 4'h8;

    // Control register fields
    localparam int CTRL_TIE = 7;
    localparam int CTRL_RIE = 6;
    localparam int CTRL_TE = 5;
    localparam int CTRL_RE = 4;
    localparam int CTRL_ADDR_WAIT_IRQ_EN = 3;
    localparam int CTRL_TX_DONE_IRQ_EN = 2;
    localparam int CTRL_CKSRC = 1;
    localparam int CTRL_CKOE = 0;

    // Status register fields
    localparam int ST_TX_EMPTY_FLAG = 7;
    localparam int ST_RX_FULL_FLAG = 6;
    localparam int ST_OVERRUN_FLAG = 5;
    localparam int ST_FER = 4;
    localparam int ST_PER = 3;
    localparam int ST_TX_DONE_FLAG = 2;
    localparam int ST_MPB = 1;
    localparam int ST_MPBT = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h84;
    // Flags that a write-zero may clear only after a read-as-one
    localparam logic [7:0] CLR_MASK = 8'hF8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to sys_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = ce ? pin_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            // Idle-high reset so no false falling edge follows reset
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_sync_out = sync_q;
endmodule
`default_nettype wire

// ===== rtl/sck_pin_ctrl.sv
// Purpose: Serial clock pin direction and internal clock output
// Assumes: half_tick pulses twice per bit time
// Notes: Pin left undriven when it serves as general I/O
`timescale 1ns/1ps
`default_nettype none
module sck_pin_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic mode_sync,
    input wire logic clk_src_sel,
    input wire logic clk_out_en,
    input wire logic half_tick,
    output logic sck_o,
    output logic sck_oe,
    output logic ext_sel
);
    logic sck_q;
    logic sck_d;
    logic oe_q;
    logic oe_d;
    logic ext_q;
    logic ext_d;

    always_comb
    begin
        sck_d = sck_q;
        oe_d = oe_q;
        ext_d = ext_q;
        if (ce)
        begin
            ext_d = clk_src_sel;
            // Sync mode ignores the output enable bit
            oe_d = !clk_src_sel && (mode_sync || clk_out_en);
            // Two toggles per bit: pin frequency equals the bit rate
            sck_d = oe_d ? (half_tick ? !sck_q : sck_q) : 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sck_q <= 1'b1;
            oe_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            sck_q <= sck_d;
            oe_q <= oe_d;
            ext_q <= ext_d;
        end
    end

    assign sck_o = sck_q;
    assign sck_oe = oe_q;
    assign ext_sel = ext_q;
endmodule
`default_nettype wire

// ===== rtl/serial_ctrl_status.sv
// Purpose: Control and status registers of the serial unit, AXI4-Lite slave
// Assumes: Shifters, baud generator and mode register sit outside, on sys_clk
// Notes: Interrupt requests are registered levels, one cycle behind their cause
// Functional notes
// - Tx-empty request while enable and tx-empty flag; drops on flag clear or disable
// - One receive interrupt enable bit gates both rx-full and rx-error requests
// - Rx requests drop on read-one-write-zero of rx flags or enable clear
// - Tx-empty sets on reset, standby, transmit disable, holding-to-shifter move
// - Transmission starts once tx-empty is cleared with transmitter enabled
// - Disabling receiver leaves rx-full and error flags untouched
// - Reception starts on start bit (async), serial clock input falling edge (sync external) or at once (sync internal)
// - Address-wait enable acts only in async multiprocessor format
// - During address wait frames are dropped and rx flags stay unset
// - Address frame sets address flag, ends wait, reopens normal reception
// - Tx-done request when last bit leaves with holding register empty
// - Tx-done request drops on tx-empty clear or its enable clear
// - Async clock select: internal free pin, internal driven out, external in
// - Sync clock source: internal driven out or external in
// - Driven async clock runs at the bit rate
// - Flag writes of one ignored; zero clears only after reading one; MPBT takes the written bit
// - Tx-done and received address flag are read-only
// - Status returns to 84 hex on reset and standby
// - Tx-empty clears by read-one-write-zero or DMA holding write
// - Control resets to zero on reset and standby, always accessible
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_status (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [serial_ctrl_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [serial_ctrl_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic mode_sync,
    input wire logic multiproc_format,
    input wire logic standby,
    input wire logic tx_load,
    input wire logic tx_last_bit,
    input wire logic dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire logic dma_rx_read,
    input wire logic rx_frame_done,
    input wire logic rx_mpb,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    input wire logic rx_busy,
    input wire logic baud_half_tick,
    input wire logic rxd_pin,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic [7:0] tx_holding,
    output logic tx_go,
    output logic rx_on,
    output logic rx_start,
    output logic rx_store,
    output logic ext_clk_sel,
    output logic ext_clk_edge,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_error_irq,
    output logic tx_done_irq
);
    import serial_ctrl_pkg::*;

    logic [7:0] ctrl_q, ctrl_d, status_q, status_d, seen_q, seen_d;
    logic [7:0] txh_q, txh_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [7:0] w_data_q, w_data_d;
    logic w_en_q, w_en_d;
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0] irq_q, irq_d;
    logic tx_go_q, tx_go_d, rx_start_q, rx_start_d, rx_store_q, rx_store_d;
    logic rxd_prev_q, rxd_prev_d, sck_prev_q, sck_prev_d, edge_q, edge_d;
    logic [1:0] pins_s;
    logic wr_go, ar_fire, st_wr, mp_wait, frame_ok, accept, overrun;
    logic [7:0] clr_v, set_v;
    logic sck_fall, rxd_fall, ext_sel;

    pin_sync #(.W(2)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .pin_in({sck_i, rxd_pin}),
        .pin_sync_out(pins_s)
    );

    sck_pin_ctrl u_sck (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .mode_sync(mode_sync),
        .clk_src_sel(ctrl_q[CTRL_CKSRC]),
        .clk_out_en(ctrl_q[CTRL_CKOE]),
        .half_tick(baud_half_tick),
        .sck_o(sck_o),
        .sck_oe(sck_oe),
        .ext_sel(ext_sel)
    );

    // Bus channels
    always_comb
    begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d = w_held_q;
        w_data_d = w_data_q;
        w_en_d = w_en_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        wr_go = aw_held_q && w_held_q && !bvalid_q;
        ar_fire = arvalid && arready_q;
        if (awvalid && awready_q)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q)
        begin
            w_held_d = 1'b1;
            w_data_d = wdata[7:0];
            w_en_d = wstrb[0];
        end
        if (bvalid_q && bready)
        begin
            bvalid_d = 1'b0;
        end
        if (wr_go)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (aw_addr_q == ADDR_CTRL || aw_addr_q == ADDR_STATUS
                || aw_addr_q == ADDR_TX_HOLD) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && rready)
        begin
            rvalid_d = 1'b0;
        end
        if (ar_fire)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (araddr)
                ADDR_CTRL: rdata_d = {24'h00_0000, ctrl_q};
                ADDR_STATUS: rdata_d = {24'h00_0000, status_q};
                ADDR_TX_HOLD: rdata_d = {24'h00_0000, txh_q};
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_held_d;
        wready_d = !w_held_d;
        arready_d = !rvalid_d && !ar_fire;
    end

    // Register file and flags
    always_comb
    begin
        ctrl_d = ctrl_q;
        txh_d = txh_q;
        st_wr = wr_go && w_en_q && aw_addr_q == ADDR_STATUS;
        mp_wait = ctrl_q[CTRL_ADDR_WAIT_IRQ_EN] && multiproc_format && !mode_sync;
        // Overrun stalls reception until software clears it
        frame_ok = rx_frame_done && ctrl_q[CTRL_RE] && !status_q[ST_OVERRUN_FLAG];
        accept = frame_ok && !(mp_wait && !rx_mpb);
        // Written zero clears only a flag seen at one; ones are ignored
        clr_v = {8{st_wr}} & ~w_data_q & seen_q & CLR_MASK;
        if (dma_tx_write)
        begin
            clr_v[ST_TX_EMPTY_FLAG] = 1'b1;
            txh_d = dma_tx_data;
        end
        if (dma_rx_read)
        begin
            clr_v[ST_RX_FULL_FLAG] = 1'b1;
        end
        overrun = status_q[ST_RX_FULL_FLAG] && !clr_v[ST_RX_FULL_FLAG];
        set_v = 8'h00;
        set_v[ST_TX_EMPTY_FLAG] = tx_load || !ctrl_q[CTRL_TE];
        // Tx-done clears only when tx-empty really clears, not while it is locked
        clr_v[ST_TX_DONE_FLAG] = clr_v[ST_TX_EMPTY_FLAG] && !set_v[ST_TX_EMPTY_FLAG];
        set_v[ST_TX_DONE_FLAG] = tx_last_bit && status_q[ST_TX_EMPTY_FLAG];
        set_v[ST_OVERRUN_FLAG] = accept && overrun;
        set_v[ST_RX_FULL_FLAG] = accept && !overrun;
        set_v[ST_FER] = accept && !overrun && rx_frame_err && !mode_sync;
        set_v[ST_PER] = accept && !overrun && rx_parity_err && !mode_sync
            && !multiproc_format;
        // Set wins over a clear in the same cycle; disabling receive clears nothing
        status_d = set_v | (status_q & ~clr_v);
        if (accept && multiproc_format && !mode_sync)
        begin
            status_d[ST_MPB] = rx_mpb;
        end
        if (st_wr)
        begin
            status_d[ST_MPBT] = w_data_q[ST_MPBT];
        end
        seen_d = st_wr ? 8'h00 : seen_q;
        if (ar_fire && araddr == ADDR_STATUS)
        begin
            seen_d = seen_q | (status_q & CLR_MASK);
        end
        if (frame_ok && mp_wait && rx_mpb)
        begin
            ctrl_d[CTRL_ADDR_WAIT_IRQ_EN] = 1'b0;
        end
        if (wr_go && w_en_q && aw_addr_q == ADDR_CTRL)
        begin
            ctrl_d = w_data_q;
        end
        if (wr_go && w_en_q && aw_addr_q == ADDR_TX_HOLD)
        begin
            txh_d = w_data_q;
        end
        if (standby)
        begin
            ctrl_d = CTRL_RESET;
            status_d = STATUS_RESET;
            seen_d = 8'h00;
        end
    end

    // Requests, pin events and shifter handshakes
    always_comb
    begin
        irq_d[0] = ctrl_q[CTRL_TIE] && status_q[ST_TX_EMPTY_FLAG];
        irq_d[1] = ctrl_q[CTRL_RIE] && status_q[ST_RX_FULL_FLAG];
        irq_d[2] = ctrl_q[CTRL_RIE] && |status_q[ST_OVERRUN_FLAG:ST_PER];
        irq_d[3] = ctrl_q[CTRL_TX_DONE_IRQ_EN] && status_q[ST_TX_DONE_FLAG];
        tx_go_d = ctrl_q[CTRL_TE] && !status_q[ST_TX_EMPTY_FLAG];
        rxd_prev_d = pins_s[0];
        sck_prev_d = pins_s[1];
        rxd_fall = rxd_prev_q && !pins_s[0];
        sck_fall = sck_prev_q && !pins_s[1];
        edge_d = ext_sel && !sck_prev_q && pins_s[1];
        if (mode_sync)
        begin
            rx_start_d = ctrl_q[CTRL_RE] && !rx_busy
                && (ctrl_q[CTRL_CKSRC] ? sck_fall : 1'b1);
        end
        else
        begin
            rx_start_d = ctrl_q[CTRL_RE] && !rx_busy && rxd_fall;
        end
        rx_store_d = set_v[ST_RX_FULL_FLAG];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            status_q <= STATUS_RESET;
            seen_q <= 8'h00;
            txh_q <= 8'h00;
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= 8'h00;
            w_en_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            irq_q <= 4'h0;
            tx_go_q <= 1'b0;
            rx_start_q <= 1'b0;
            rx_store_q <= 1'b0;
            rxd_prev_q <= 1'b1;
            sck_prev_q <= 1'b1;
            edge_q <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            seen_q <= seen_d;
            txh_q <= txh_d;
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q <= w_held_d;
            w_data_q <= w_data_d;
            w_en_q <= w_en_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            irq_q <= irq_d;
            tx_go_q <= tx_go_d;
            rx_start_q <= rx_start_d;
            rx_store_q <= rx_store_d;
            rxd_prev_q <= rxd_prev_d;
            sck_prev_q <= sck_prev_d;
            edge_q <= edge_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign tx_holding = txh_q;
    assign tx_go = tx_go_q;
    assign rx_on = ctrl_q[CTRL_RE];
    assign rx_start = rx_start_q;
    assign rx_store = rx_store_q;
    assign ext_clk_sel = ext_sel;
    assign ext_clk_edge = edge_q;
    assign tx_empty_irq = irq_q[0];
    assign rx_full_irq = irq_q[1];
    assign rx_error_irq = irq_q[2];
    assign tx_done_irq = irq_q[3];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_tx_empty_flag_locked: assert property (ce && !ctrl_q[CTRL_TE] |=> status_q[ST_TX_EMPTY_FLAG])
        else $error("tx empty flag not locked while disabled");
    a_txe_request: assert property (ce |=> tx_empty_irq ==
        ($past(ctrl_q[CTRL_TIE]) && $past(status_q[ST_TX_EMPTY_FLAG])))
        else $error("tx empty request not enable and flag");
    a_rx_gated: assert property (ce && !ctrl_q[CTRL_RIE] |=> !rx_full_irq && !rx_error_irq)
        else $error("rx request without enable");
    a_rx_full_flag_cause: assert property ($rose(status_q[ST_RX_FULL_FLAG]) |-> $past(rx_frame_done))
        else $error("rx full set without a frame");
    a_wait_drops: assert property (ce && mp_wait && frame_ok && !rx_mpb |=> !rx_store && $stable(status_q[ST_RX_FULL_FLAG:ST_FER]) || standby)
        else $error("frame stored during address wait");
    a_addr_frame: assert property (ce && !standby && frame_ok && mp_wait && rx_mpb |=> !ctrl_q[CTRL_ADDR_WAIT_IRQ_EN] && status_q[ST_MPB])
        else $error("address frame did not end the wait");
    a_standby_reset: assert property (ce && standby |=> status_q == STATUS_RESET && ctrl_q == CTRL_RESET)
        else $error("standby did not restore registers");
    a_tx_done_flag_source: assert property ($rose(status_q[ST_TX_DONE_FLAG]) |-> $past(tx_last_bit) || $past(standby))
        else $error("tx done set without last bit");
    a_dma_clear: assert property (ce && dma_tx_write && !tx_load && ctrl_q[CTRL_TE] && !standby |=> !status_q[ST_TX_EMPTY_FLAG])
        else $error("dma write left tx empty set");
    a_sck_drive: assert property (ce && !mode_sync && !ctrl_q[CTRL_CKSRC]
        && ctrl_q[CTRL_CKOE] |=> sck_oe)
        else $error("internal clock not driven out");
    c_tx_start: cover property (tx_go && ctrl_q[CTRL_TE]);
    c_addr_frame: cover property (frame_ok && mp_wait && rx_mpb);
    c_overrun: cover property (set_v[ST_OVERRUN_FLAG]);
endmodule
`default_nettype wire

// ===== bench/serial_peer.sv
// Purpose: Remote serial peer driving the receive data and serial clock pins
// Assumes: One frame per rising edge of go
// Notes: Clock stands high and data idles high outside frames
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic go,
    input wire logic [4:0] clks_per_bit,
    output logic rxd,
    output logic sck
);
    initial
    begin
        rxd = 1'h1;
        sck = 1'h1;
    end
    always @(posedge go)
    begin
        // Start bit first, then toggling data so every bit differs
        rxd = 1'h0;
        repeat (9)
        begin
            // Async external clock runs sixteen periods per bit
            repeat (clks_per_bit)
            begin
                #62.5 sck = 1'h0;
                #62.5 sck = 1'h1;
            end
            rxd = ~rxd;
        end
        rxd = 1'h1;
    end
endmodule
`default_nettype wire

// ===== bench/serial_ctrl_status_tb_top.sv
// Purpose: Self-checking bench for the serial control and status block
// Assumes: Bus master waits on handshakes, never on fixed latencies
// Notes: Shifter side events are driven as single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_status_tb_top;
    import serial_ctrl_pkg::*;
    logic sys_clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mode_sync, multiproc_format, standby;
    logic tx_load, tx_last_bit, dma_tx_write, rx_frame_done, rx_mpb, rx_frame_err;
    logic baud_half_tick, rxd_pin, sck_peer, sck_w, peer_go, sck_o, sck_oe, tx_go;
    logic rx_start, ext_clk_sel, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0] bresp, rresp, rd_resp;
    logic [7:0] dma_tx_data, tx_holding;
    logic [4:0] peer_div;
    int err_count, n_compared, hcnt;

    serial_ctrl_status dut_u (
        .sys_clk, .rst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .mode_sync, .multiproc_format, .standby, .tx_load, .tx_last_bit,
        .dma_tx_write, .dma_tx_data, .dma_rx_read(1'h0), .rx_frame_done, .rx_mpb,
        .rx_frame_err, .rx_parity_err(1'h0), .rx_busy(1'h0), .baud_half_tick, .rxd_pin,
        .sck_i(sck_w), .sck_o, .sck_oe, .tx_holding, .tx_go, .rx_on(), .rx_start,
        .rx_store(), .ext_clk_sel, .ext_clk_edge(), .tx_empty_irq, .rx_full_irq,
        .rx_error_irq, .tx_done_irq);
    serial_peer peer_u (.go(peer_go), .clks_per_bit(peer_div), .rxd(rxd_pin), .sck(sck_peer));
    // Pin level: device drives when enabled, otherwise the peer
    assign sck_w = sck_oe ? sck_o : sck_peer;

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        hcnt <= hcnt + 1;
        baud_half_tick <= (hcnt % 8 == 7);
    end

    task finish_test;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 50)
        begin
            chk(8'h00, 8'h01, "bus timeout");
            finish_test;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end
        while (!bvalid && n < 50);
        bready <= 1'h0;
        hang(n);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (arready)
                arvalid <= 1'h0;
        end
        while (!rvalid && n < 50);
        rready <= 1'h0;
        rd_val = rdata;
        rd_resp = rresp;
        hang(n);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] e,
        input string m);
        rd(a);
        chk(rd_val[7:0] & mask, e, m);
    endtask
    task st;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic frame(input logic address_flag_bit);
        @(posedge sys_clk);
        rx_frame_done <= 1'h1;
        rx_mpb <= address_flag_bit;
        @(posedge sys_clk) rx_frame_done <= 1'h0;
        st;
    endtask
    function automatic logic [7:0] irqs();
        return {tx_go, 3'h0, tx_empty_irq, tx_done_irq, rx_full_irq, rx_error_irq};
    endfunction

    task t_regs;
        rc(ADDR_CTRL, 8'hFF, 8'h00, "ctrl reset");
        rc(ADDR_STATUS, 8'hFF, 8'h84, "status reset");
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        rc(ADDR_STATUS, 8'hFF, 8'h85, "status protect");
        rd(4'hC);
        chk({6'h0, rd_resp}, {6'h0, RESP_SLVERR}, "unmapped resp");
        chk(rd_val[7:0], 8'h00, "unmapped data");
    endtask
    task t_tx;
        wr(ADDR_CTRL, 8'hA4);
        st;
        chk(irqs(), 8'h0C, "tx irqs");
        rc(ADDR_STATUS, 8'hFF, 8'h85, "tx status");
        wr(ADDR_STATUS, 8'h00);
        st;
        chk(irqs(), 8'h80, "tx go");
        rc(ADDR_STATUS, 8'hFF, 8'h00, "tx empty clear");
        @(posedge sys_clk) tx_load <= 1'h1;
        @(posedge sys_clk) tx_load <= 1'h0;
        st;
        chk(irqs(), 8'h08, "tx load");
        @(posedge sys_clk) tx_last_bit <= 1'h1;
        @(posedge sys_clk) tx_last_bit <= 1'h0;
        st;
        chk(irqs(), 8'h0C, "tx done");
        @(posedge sys_clk) dma_tx_write <= 1'h1;
        @(posedge sys_clk) dma_tx_write <= 1'h0;
        st;
        chk(tx_holding, 8'h5A, "dma data");
        chk(irqs(), 8'h80, "dma clears empty");
        wr(ADDR_CTRL, 8'h00);
        rc(ADDR_STATUS, 8'h80, 8'h80, "tx disable");
    endtask
    task t_rx;
        wr(ADDR_CTRL, 8'h50);
        frame(1'h0);
        chk(irqs(), 8'h02, "rx full irq");
        frame(1'h0);
        chk(irqs(), 8'h03, "overrun irq");
        wr(ADDR_CTRL, 8'h40);
        rc(ADDR_STATUS, 8'h78, 8'h60, "rx off keeps");
        wr(ADDR_STATUS, 8'h00);
        st;
        chk(irqs(), 8'h00, "rx clear");
        rc(ADDR_STATUS, 8'h78, 8'h00, "rx flags clear");
        wr(ADDR_CTRL, 8'h10);
        frame(1'h0);
        chk(irqs(), 8'h00, "rx irq off");
        wr(ADDR_CTRL, 8'h50);
        st;
        chk(irqs(), 8'h02, "rx irq on");
        wr(ADDR_CTRL, 8'h10);
        st;
        chk(irqs(), 8'h00, "rx enable clear");
    endtask
    task t_mp;
        rd(ADDR_STATUS);
        wr(ADDR_STATUS, 8'h00);
        @(posedge sys_clk) multiproc_format <= 1'h1;
        wr(ADDR_CTRL, 8'h58);
        frame(1'h0);
        rc(ADDR_STATUS, 8'h7A, 8'h00, "wait drops");
        frame(1'h1);
        chk(irqs(), 8'h02, "rx irq back");
        rc(ADDR_CTRL, 8'hFF, 8'h50, "wait ended");
        rc(ADDR_STATUS, 8'h42, 8'h42, "address frame");
        wr(ADDR_STATUS, 8'h00);
        @(posedge sys_clk) mode_sync <= 1'h1;
        wr(ADDR_CTRL, 8'h58);
        frame(1'h0);
        rc(ADDR_STATUS, 8'h40, 8'h40, "sync ignores wait");
        @(posedge sys_clk) multiproc_format <= 1'h0;
    endtask
    task t_clk;
        int n;
        logic prev;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk) mode_sync <= i[2];
            wr(ADDR_CTRL, {6'h0, i[1:0]});
            st;
            chk({6'h0, sck_oe, ext_clk_sel}, {6'h0, !i[1] && (i[2] || i[0]), i[1]},
                "clock select");
        end
        @(posedge sys_clk) mode_sync <= 1'h0;
        wr(ADDR_CTRL, 8'h01);
        n = 0;
        prev = sck_o;
        // 20 half ticks make ten bit times
        repeat (160)
        begin
            @(posedge sys_clk);
            if (sck_o && !prev)
                n++;
            prev = sck_o;
        end
        chk({7'h0, n >= 9 && n <= 11}, 8'h01, "clock out rate");
    endtask
    task automatic t_link(input logic sync, input logic [7:0] c);
        int n;
        @(posedge sys_clk) mode_sync <= sync;
        peer_div <= sync ? 5'h01 : 5'h10;
        wr(ADDR_CTRL, c);
        @(posedge sys_clk) peer_go <= 1'h1;
        n = 0;
        while (rx_start !== 1'h1 && n < 60)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({7'h0, rx_start}, 8'h01, "reception start");
        // Let the whole frame pass so the next rising go is not missed
        repeat (1900) @(posedge sys_clk);
        peer_go <= 1'h0;
    endtask
    task t_standby;
        wr(ADDR_CTRL, 8'hA4);
        @(posedge sys_clk) {ce, standby} <= 2'h1;
        @(posedge sys_clk) {ce, standby} <= 2'h2;
        rc(ADDR_CTRL, 8'hFF, 8'hA4, "frozen standby");
        @(posedge sys_clk) standby <= 1'h1;
        @(posedge sys_clk) standby <= 1'h0;
        rc(ADDR_CTRL, 8'hFF, 8'h00, "standby ctrl");
        rc(ADDR_STATUS, 8'hFF, 8'h84, "standby status");
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, mode_sync, multiproc_format} = '0;
        {standby, tx_load, tx_last_bit, dma_tx_write, rx_frame_done, rx_mpb} = '0;
        {rx_frame_err, peer_go, baud_half_tick} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h1;
        dma_tx_data = 8'h5A;
        peer_div = 5'h01;
        ce = 1'h1;
        err_count = 0;
        n_compared = 0;
        hcnt = 0;
        rst = 1'h1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        t_regs;
        t_tx;
        t_rx;
        t_mp;
        t_clk;
        t_link(1'h0, 8'h12);
        t_link(1'h1, 8'h12);
        t_standby;
        finish_test;
    end
endmodule
`default_nettype wire
